// ### core/ncmo_pkg.sv
// Package with constants and types for the NAND cached multi-page operation controller.
// Contract
// - Restart cached read when block changes; the controller only flags rsp_o.error and still sends 31h or 3Fh.
// - Same page bits, one block per district.
// - Multi read is 60h, addr, 60h, addr, 30h.
// - Hold write-protect high during multi read.
// - Result bits valid only with ready bits.
// - Step 64 pages, terminate with 80h-10h.
package ncmo_pkg;

  // ----------------------------------------------------------------
  // Commands
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_READ1      = 8'h00;
  localparam logic [7:0] CMD_READ2      = 8'h30;
  localparam logic [7:0] CMD_CACHE_RD   = 8'h31;
  localparam logic [7:0] CMD_CACHE_LAST = 8'h3F;
  localparam logic [7:0] CMD_MP_SETUP   = 8'h60;
  localparam logic [7:0] CMD_DATA_IN    = 8'h80;
  localparam logic [7:0] CMD_COL_CHG    = 8'h85;
  localparam logic [7:0] CMD_PROG       = 8'h10;
  localparam logic [7:0] CMD_MP_PROG    = 8'h11;
  localparam logic [7:0] CMD_CACHE_PROG = 8'h15;
  localparam logic [7:0] CMD_STATUS     = 8'h70;
  localparam logic [7:0] CMD_STATUS_MP  = 8'h71;
  localparam logic [7:0] CMD_RESET      = 8'hFF;

  // ----------------------------------------------------------------
  // Geometry and timing
  // ----------------------------------------------------------------
  localparam int          PAGES_PER_BLOCK  = 64;
  localparam int          DISTRICT_BLOCKS  = 512;
  localparam int          CLK_PERIOD_NS    = 25;
  localparam int          STROBE_LOW_NS    = 25;
  localparam int          STROBE_HIGH_NS   = 25;
  localparam int          STROBE_LOW_CYC   = (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          STROBE_HIGH_CYC  = (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          BUSY_SETTLE_NS   = 100;
  localparam int          BUSY_SETTLE_CYC  = (BUSY_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0]  TIMER_RESET      = 4'h0;

  // ----------------------------------------------------------------
  // Status bit positions
  // ----------------------------------------------------------------
  localparam int ST_OVERALL  = 0;
  localparam int ST_D0_S1    = 1;
  localparam int ST_D1_S1    = 2;
  localparam int ST_D0_S2    = 3;
  localparam int ST_D1_S2    = 4;
  localparam int ST_READY    = 5;
  localparam int ST_CREADY   = 6;
  localparam int ST_NOT_WP   = 7;

  // ----------------------------------------------------------------
  // User operations
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    NCMO_OP_READ,
    NCMO_OP_CACHE_NEXT,
    NCMO_OP_CACHE_LAST,
    NCMO_OP_MP_READ,
    NCMO_OP_PROG,
    NCMO_OP_CACHE_PROG,
    NCMO_OP_COL_CHG,
    NCMO_OP_STATUS,
    NCMO_OP_STATUS_MP,
    NCMO_OP_RESET,
    NCMO_OP_DATA_OUT,
    NCMO_OP_DATA_IN
  } ncmo_op_t;

  typedef struct packed {
    ncmo_op_t    op;
    logic [11:0] column;
    logic [15:0] page;
    logic [15:0] page2;
    logic [7:0]  data;
    logic        last;
  } ncmo_req_t;

  typedef struct packed {
    logic [7:0] data;
    logic       valid;
    logic       error;
  } ncmo_rsp_t;

  typedef struct packed {
    logic       cle;
    logic       ale;
    logic       ce_n;
    logic       we_n;
    logic       re_n;
    logic       wp_n;
  } ncmo_pins_t;

  // Splits a page address into its district bit.
  function automatic logic ncmo_district(input logic [15:0] page);
    return page[15];
  endfunction : ncmo_district

  // Checks that two page addresses form a legal district pair.
  function automatic logic ncmo_pair_ok(input logic [15:0] a, input logic [15:0] b);
    return (a[5:0] == b[5:0]) && (a[15] != b[15]);
  endfunction : ncmo_pair_ok

endpackage : ncmo_pkg

// ### core/ncmo_strobe.sv
// Byte cycle engine that drives one latch or read strobe cycle on the flash pins.
`timescale 1ns/1ps
`default_nettype none
module ncmo_strobe
  import ncmo_pkg::*;
(
  input  wire logic       ref_clk_i,
  input  wire logic       reset_i,
  input  wire logic       go_i,
  input  wire logic       cle_i,
  input  wire logic       ale_i,
  input  wire logic       rd_i,
  input  wire logic [7:0] byte_i,
  input  wire logic [7:0] io_i,
  output logic            cle_o,
  output logic            ale_o,
  output logic            we_n_o,
  output logic            re_n_o,
  output logic [7:0]      io_o,
  output logic            io_oe_o,
  output logic [7:0]      rd_data_o,
  output logic            done_o
);

  // ----------------------------------------------------------------
  // Cycle sequencing
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {S_IDLE, S_LOW, S_HIGH} ncmo_strobe_state_t;
  ncmo_strobe_state_t state_q;
  logic [3:0]         cnt_q;
  logic               rd_q;

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      state_q <= S_IDLE;
      cnt_q   <= TIMER_RESET;
      rd_q    <= 1'b0;
      done_o  <= 1'b0;
    end else begin
      done_o <= 1'b0;
      unique case (state_q)
        S_IDLE: begin
          if (go_i) begin
            state_q <= S_LOW;
            cnt_q   <= 4'(STROBE_LOW_CYC - 1);
            rd_q    <= rd_i;
          end
        end
        S_LOW: begin
          if (cnt_q == 4'h0) begin
            state_q <= S_HIGH;
            cnt_q   <= 4'(STROBE_HIGH_CYC - 1);
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        S_HIGH: begin
          if (cnt_q == 4'h0) begin
            state_q <= S_IDLE;
            done_o  <= 1'b1;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      cle_o     <= 1'b0;
      ale_o     <= 1'b0;
      we_n_o    <= 1'b1;
      re_n_o    <= 1'b1;
      io_o      <= 8'h00;
      io_oe_o   <= 1'b0;
      rd_data_o <= 8'h00;
    end else begin
      if (state_q == S_IDLE && go_i) begin
        cle_o   <= cle_i;
        ale_o   <= ale_i;
        io_o    <= byte_i;
        io_oe_o <= !rd_i;
        we_n_o  <= rd_i;
        re_n_o  <= !rd_i;
      end else if (state_q == S_LOW && cnt_q == 4'h0) begin
        we_n_o <= 1'b1;
        re_n_o <= 1'b1;
      end else if (state_q == S_HIGH && cnt_q == 4'h0) begin
        cle_o   <= 1'b0;
        ale_o   <= 1'b0;
        io_oe_o <= 1'b0;
      end
      // Read data is taken while the registered pin strobe is still low.
      if (rd_q && state_q == S_HIGH && cnt_q == 4'(STROBE_HIGH_CYC - 1)) begin
        rd_data_o <= io_i;
      end
    end
  end

endmodule : ncmo_strobe
`default_nettype wire

// ### core/ncmo_ctrl.sv
// Host controller that sequences cached and multi-page flash operations on the pins.
`timescale 1ns/1ps
`default_nettype none
module ncmo_ctrl
  import ncmo_pkg::*;
#(
  parameter int BUSY_TIMEOUT_CYC = 40000
) (
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  input  wire ncmo_req_t   req_i,
  input  wire logic        req_valid_i,
  output logic             req_ready_o,
  output ncmo_rsp_t        rsp_o,
  output logic             busy_o,
  input  wire logic        wp_allow_i,
  output ncmo_pins_t       pins_o,
  output logic [7:0]       io_o,
  output logic             io_oe_o,
  input  wire logic [7:0]  io_i,
  input  wire logic        ready_busy_n_i
);

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    Q_IDLE, Q_ISSUE, Q_WAIT_STROBE, Q_SETTLE, Q_WAIT_READY, Q_DONE
  } ncmo_seq_state_t;

  ncmo_seq_state_t state_q;
  ncmo_req_t       req_q;
  logic [3:0]      step_q;
  logic [3:0]      nsteps_q;
  logic            wait_busy_q;
  logic            want_rd_q;
  logic [31:0]     timer_q;
  logic            go_q;
  logic            b_cle;
  logic            b_ale;
  logic            b_rd;
  logic [7:0]      b_byte;
  logic            s_done;
  logic [7:0]      s_rd_data;
  logic            s_cle;
  logic            s_ale;
  logic            s_we_n;
  logic            s_re_n;
  logic [7:0]      s_io;
  logic            s_io_oe;
  logic            dev_busy_q;
  logic [15:0]     rd_page_q;

  // Commands that the device takes while busy.
  function automatic logic busy_safe(input ncmo_op_t op);
    return op == NCMO_OP_STATUS || op == NCMO_OP_STATUS_MP || op == NCMO_OP_RESET;
  endfunction : busy_safe

  // Number of steps that an operation needs: its byte cycles, plus one busy-wait step for NCMO_OP_READ only.
  function automatic logic [3:0] op_steps(input ncmo_op_t op);
    unique case (op)
      NCMO_OP_READ:       return 4'd7;
      NCMO_OP_CACHE_NEXT: return 4'd1;
      NCMO_OP_CACHE_LAST: return 4'd1;
      NCMO_OP_MP_READ:    return 4'd11;
      NCMO_OP_PROG:       return 4'd5;
      NCMO_OP_CACHE_PROG: return 4'd5;
      NCMO_OP_COL_CHG:    return 4'd3;
      NCMO_OP_STATUS:     return 4'd2;
      NCMO_OP_STATUS_MP:  return 4'd2;
      NCMO_OP_RESET:      return 4'd1;
      NCMO_OP_DATA_OUT:   return 4'd1;
      NCMO_OP_DATA_IN:    return 4'd1;
      default:            return 4'd1;
    endcase
  endfunction : op_steps

  // Byte for one address cycle: column low, column high, page low, page high.
  function automatic logic [7:0] addr_byte(input logic [1:0] idx, input logic [11:0] col,
                                           input logic [15:0] pg);
    unique case (idx)
      2'd0: return col[7:0];
      2'd1: return {4'h0, col[11:8]};
      2'd2: return pg[7:0];
      2'd3: return pg[15:8];
    endcase
  endfunction : addr_byte

  // ----------------------------------------------------------------
  // Byte plan for the current step
  // ----------------------------------------------------------------
  always_comb begin
    b_cle  = 1'b0;
    b_ale  = 1'b0;
    b_rd   = 1'b0;
    b_byte = 8'h00;
    unique case (req_q.op)
      NCMO_OP_READ: begin
        b_cle  = (step_q == 4'd0) || (step_q == 4'd5);
        b_ale  = (step_q >= 4'd1) && (step_q <= 4'd4);
        b_byte = (step_q == 4'd0) ? CMD_READ1 :
                 (step_q == 4'd5) ? CMD_READ2 : addr_byte(2'(step_q - 4'd1), req_q.column, req_q.page);
        b_rd   = (step_q == 4'd6);
      end
      NCMO_OP_CACHE_NEXT: begin
        b_cle  = 1'b1;
        b_byte = CMD_CACHE_RD;
      end
      NCMO_OP_CACHE_LAST: begin
        b_cle  = 1'b1;
        b_byte = CMD_CACHE_LAST;
      end
      NCMO_OP_MP_READ: begin
        // Both districts are sent in the order given; either order is legal.
        b_cle = (step_q == 4'd0) || (step_q == 4'd5) || (step_q == 4'd10);
        b_ale = !b_cle;
        if (step_q == 4'd0 || step_q == 4'd5) begin
          b_byte = CMD_MP_SETUP;
        end else if (step_q == 4'd10) begin
          b_byte = CMD_READ2;
        end else if (step_q < 4'd5) begin
          b_byte = addr_byte(2'(step_q - 4'd1), req_q.column, req_q.page);
        end else begin
          b_byte = addr_byte(2'(step_q - 4'd6), req_q.column, req_q.page2);
        end
      end
      NCMO_OP_PROG, NCMO_OP_CACHE_PROG: begin
        b_cle  = (step_q == 4'd0);
        b_ale  = (step_q != 4'd0);
        b_byte = (step_q == 4'd0) ? CMD_DATA_IN : addr_byte(2'(step_q - 4'd1), req_q.column, req_q.page);
      end
      NCMO_OP_COL_CHG: begin
        b_cle  = (step_q == 4'd0);
        b_ale  = (step_q != 4'd0);
        b_byte = (step_q == 4'd0) ? CMD_COL_CHG : addr_byte(2'(step_q - 4'd1), req_q.column, req_q.page);
      end
      NCMO_OP_STATUS, NCMO_OP_STATUS_MP: begin
        b_cle  = (step_q == 4'd0);
        b_rd   = (step_q == 4'd1);
        b_byte = (req_q.op == NCMO_OP_STATUS_MP) ? CMD_STATUS_MP : CMD_STATUS;
      end
      NCMO_OP_RESET: begin
        b_cle  = 1'b1;
        b_byte = CMD_RESET;
      end
      NCMO_OP_DATA_OUT: begin
        b_rd = 1'b1;
      end
      NCMO_OP_DATA_IN: begin
        b_cle  = req_q.last;
        b_byte = req_q.last ? req_q.data : req_q.data;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      state_q     <= Q_IDLE;
      req_q       <= '0;
      step_q      <= 4'h0;
      nsteps_q    <= 4'h0;
      wait_busy_q <= 1'b0;
      want_rd_q   <= 1'b0;
      timer_q     <= 32'h0;
      rd_page_q   <= 16'h0;
      go_q        <= 1'b0;
      req_ready_o <= 1'b0;
      rsp_o       <= '0;
      busy_o      <= 1'b0;
    end else begin
      go_q        <= 1'b0;
      rsp_o.valid <= 1'b0;
      req_ready_o <= (state_q == Q_IDLE) && !req_ready_o;
      unique case (state_q)
        Q_IDLE: begin
          busy_o <= 1'b0;
          // Commands other than status and reset wait for the device to be ready.
          if (req_valid_i && req_ready_o && (busy_safe(req_i.op) || ready_busy_n_i)) begin
            req_q    <= req_i;
            step_q   <= 4'h0;
            nsteps_q <= op_steps(req_i.op);
            busy_o   <= 1'b1;
            state_q  <= Q_ISSUE;
            rsp_o.error <= (req_i.op == NCMO_OP_MP_READ &&
                            !ncmo_pair_ok(req_i.page, req_i.page2)) ||
                           ((req_i.op == NCMO_OP_CACHE_NEXT || req_i.op == NCMO_OP_CACHE_LAST) &&
                            rd_page_q[5:0] == 6'(PAGES_PER_BLOCK - 1));
            if (req_i.op == NCMO_OP_READ || req_i.op == NCMO_OP_CACHE_NEXT) begin
              rd_page_q <= (req_i.op == NCMO_OP_READ) ? req_i.page : rd_page_q + 16'h1;
            end
            // Last data byte carries the closing 10h or 15h as a command.
            wait_busy_q <= (req_i.op == NCMO_OP_CACHE_NEXT) || (req_i.op == NCMO_OP_CACHE_LAST) ||
                           (req_i.op == NCMO_OP_READ) || (req_i.op == NCMO_OP_MP_READ) ||
                           (req_i.op == NCMO_OP_RESET) ||
                           (req_i.op == NCMO_OP_DATA_IN && req_i.last);
          end
        end
        Q_ISSUE: begin
          if (req_q.op == NCMO_OP_READ && step_q == 4'd6) begin
            state_q <= Q_SETTLE;
            timer_q <= 32'(BUSY_SETTLE_CYC);
          end else begin
            go_q      <= 1'b1;
            want_rd_q <= b_rd;
            state_q   <= Q_WAIT_STROBE;
          end
        end
        Q_WAIT_STROBE: begin
          if (s_done) begin
            step_q <= step_q + 4'h1;
            if (want_rd_q) begin
              rsp_o.data  <= s_rd_data;
              rsp_o.valid <= 1'b1;
              rsp_o.error <= rsp_o.error || (busy_safe(req_q.op) &&
                             s_rd_data[ST_READY] && s_rd_data[ST_OVERALL]);
            end
            if (step_q + 4'h1 >= nsteps_q) begin
              state_q <= wait_busy_q ? Q_SETTLE : Q_DONE;
              timer_q <= 32'(BUSY_SETTLE_CYC);
            end else begin
              state_q <= Q_ISSUE;
            end
          end
        end
        Q_SETTLE: begin
          timer_q <= timer_q - 32'h1;
          if (timer_q == 32'h0) begin
            state_q <= Q_WAIT_READY;
            timer_q <= 32'(BUSY_TIMEOUT_CYC);
          end
        end
        Q_WAIT_READY: begin
          timer_q <= timer_q - 32'h1;
          if (ready_busy_n_i || timer_q == 32'h0) begin
            rsp_o.error <= rsp_o.error || !ready_busy_n_i;
            state_q     <= Q_DONE;
          end
        end
        Q_DONE: begin
          busy_o  <= 1'b0;
          state_q <= Q_IDLE;
        end
        default: state_q <= Q_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Device busy tracking and pin register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      dev_busy_q <= 1'b0;
      pins_o     <= '{cle: 1'b0, ale: 1'b0, ce_n: 1'b1, we_n: 1'b1, re_n: 1'b1, wp_n: 1'b0};
    end else begin
      dev_busy_q  <= !ready_busy_n_i;
      pins_o.cle  <= s_cle;
      pins_o.ale  <= s_ale;
      pins_o.we_n <= s_we_n;
      pins_o.re_n <= s_re_n;
      pins_o.ce_n <= (state_q == Q_IDLE) && !dev_busy_q;
      pins_o.wp_n <= wp_allow_i || (state_q != Q_IDLE && req_q.op == NCMO_OP_MP_READ);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      io_o    <= 8'h00;
      io_oe_o <= 1'b0;
    end else begin
      io_o    <= s_io;
      io_oe_o <= s_io_oe;
    end
  end

  ncmo_strobe u_strobe (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .go_i      (go_q),
    .cle_i     (b_cle),
    .ale_i     (b_ale),
    .rd_i      (b_rd),
    .byte_i    (b_byte),
    .io_i      (io_i),
    .cle_o     (s_cle),
    .ale_o     (s_ale),
    .we_n_o    (s_we_n),
    .re_n_o    (s_re_n),
    .io_o      (s_io),
    .io_oe_o   (s_io_oe),
    .rd_data_o (s_rd_data),
    .done_o    (s_done)
  );

endmodule : ncmo_ctrl
`default_nettype wire

// ### test/ncmo_ctrl_props.sv
// Checker for the port behaviour of the flash controller.
`timescale 1ns/1ps
`default_nettype none
module ncmo_ctrl_props
  import ncmo_pkg::*;
#(
  parameter int BUSY_TIMEOUT_CYC = 40000
) (
  input wire logic       ref_clk_i,
  input wire logic       reset_i,
  input wire ncmo_req_t  req_i,
  input wire logic       req_valid_i,
  input wire logic       req_ready_o,
  input wire ncmo_rsp_t  rsp_o,
  input wire logic       busy_o,
  input wire logic       wp_allow_i,
  input wire ncmo_pins_t pins_o,
  input wire logic [7:0] io_o,
  input wire logic       io_oe_o,
  input wire logic [7:0] io_i,
  input wire logic       ready_busy_n_i
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  int  busy_cnt_q;
  logic mp_q;
  wire logic take = req_valid_i && req_ready_o && ready_busy_n_i;
  wire logic bad_pair = (req_i.page[5:0] != req_i.page2[5:0]) || (req_i.page[15] == req_i.page2[15]);
  // Counts how long the controller has been busy.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || !busy_o) busy_cnt_q <= 0;
    else busy_cnt_q <= busy_cnt_q + 1;
  end
  // Marks a taken multi-page read until the controller is idle again.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) mp_q <= 1'b0;
    else if (take && req_i.op == NCMO_OP_MP_READ) mp_q <= 1'b1;
    else if (!busy_o) mp_q <= 1'b0;
  end
  wp_follow_a: assert property (!wp_allow_i [*2] ##0 !mp_q |-> !pins_o.wp_n)
    else $error("write protect released without permission");
  mp_wp_a: assert property (mp_q && $past(mp_q) |-> pins_o.wp_n)
    else $error("write protect low during multi-page read");
  latch_excl_a: assert property (!(pins_o.cle && pins_o.ale))
    else $error("command and address latch both high");
  pair_error_a: assert property (take && req_i.op == NCMO_OP_MP_READ && bad_pair
    |-> ##[1:600] rsp_o.error) else $error("illegal district pair not flagged");
  io_contend_a: assert property (!(io_oe_o && !pins_o.re_n))
    else $error("bus driven while device outputs");
  strobe_sel_a: assert property ($fell(pins_o.we_n) || $fell(pins_o.re_n) |-> !pins_o.ce_n)
    else $error("strobe without chip select");
  read_quiet_a: assert property (!pins_o.re_n |-> !pins_o.cle && !pins_o.ale && pins_o.we_n)
    else $error("read strobe during latch cycle");
  read_settle_a: assert property ($rose(pins_o.we_n) && $past(pins_o.cle) && $past(io_o) == 8'h30
    |-> (pins_o.re_n && busy_o) [*4]) else $error("read strobe during transfer settle");
  busy_bound_a: assert property (busy_cnt_q < BUSY_TIMEOUT_CYC + 1000)
    else $error("controller busy too long");
  cover property (take && req_i.op == NCMO_OP_MP_READ);
  cover property ($rose(rsp_o.error));
  cover property (rsp_o.valid && pins_o.wp_n);
endmodule : ncmo_ctrl_props
bind ncmo_ctrl ncmo_ctrl_props #(.BUSY_TIMEOUT_CYC(BUSY_TIMEOUT_CYC)) u_props (
  .ref_clk_i(ref_clk_i), .reset_i(reset_i), .req_i(req_i), .req_valid_i(req_valid_i),
  .req_ready_o(req_ready_o), .rsp_o(rsp_o), .busy_o(busy_o), .wp_allow_i(wp_allow_i),
  .pins_o(pins_o), .io_o(io_o), .io_oe_o(io_oe_o), .io_i(io_i), .ready_busy_n_i(ready_busy_n_i));
`default_nettype wire

// ### test/ncmo_flash_model.sv
// Behavioural model of the flash device on the far side of the controller.
`timescale 1ns/1ps
`default_nettype none
module ncmo_flash_model
  import ncmo_pkg::*;
#(
  parameter int         BUSY_CYC = 20,
  parameter logic [5:0] FAIL_PG  = 6'h05
) (
  input  wire logic       ref_clk_i,
  input  wire ncmo_pins_t pins_i,
  input  wire logic [7:0] bus_i,
  output logic [7:0]      bus_o,
  output logic            ready_busy_n_o
);
  logic [7:0]  mem [int];
  logic [7:0]  wbuf [int];
  logic [7:0]  dout = 8'h00;
  logic [15:0] pg = '0, cpg = '0, bpg = '0;
  logic [11:0] col = '0;
  logic [1:0]  s1 = '0, s2 = '0;
  logic        stat = 1'b0;
  int          acnt = 0, cyc = 0, bend = 0;
  // A released bus shows the inverse of the last byte.
  assign bus_o = pins_i.re_n ? ~dout : dout;
  assign ready_busy_n_o = (cyc >= bend);
  always @(posedge ref_clk_i) cyc <= cyc + 1;
  always @(posedge pins_i.we_n) begin
    if (!pins_i.ce_n && pins_i.cle) begin
      acnt = 0;
      stat = (bus_i == CMD_STATUS || bus_i == CMD_STATUS_MP);
      if (bus_i == CMD_READ2 || bus_i == CMD_CACHE_RD || bus_i == CMD_CACHE_LAST) begin
        cpg = (bus_i == CMD_READ2) ? pg : bpg;
        if (bus_i != CMD_CACHE_LAST) bpg = cpg + 16'h1;
        if (bus_i != CMD_READ2) col = '0;
        bend = cyc + BUSY_CYC;
      end
      if (bus_i == CMD_DATA_IN) wbuf.delete();
      if (bus_i == CMD_PROG || bus_i == CMD_CACHE_PROG || bus_i == CMD_MP_PROG) begin
        foreach (wbuf[k]) mem[{4'h0, pg, k[11:0]}] = wbuf[k];
        s2[pg[15]] = s1[pg[15]];
        s1[pg[15]] = (pg[5:0] == FAIL_PG);
        bend = cyc + BUSY_CYC;
      end
    end else if (!pins_i.ce_n && pins_i.ale) begin
      if (acnt == 0) col[7:0] = bus_i;
      if (acnt == 1) col[11:8] = bus_i[3:0];
      if (acnt == 2) pg[7:0] = bus_i;
      if (acnt == 3) pg[15:8] = bus_i;
      acnt++;
    end else if (!pins_i.ce_n) begin
      wbuf[col] = bus_i;
      col++;
    end
  end
  always @(negedge pins_i.re_n) begin
    if (stat) dout = {pins_i.wp_n, ready_busy_n_o, ready_busy_n_o, s2, s1, |s1};
    else begin
      dout = mem.exists({4'h0, cpg, col}) ? mem[{4'h0, cpg, col}] : cpg[7:0] ^ col[7:0] ^ 8'h5A;
      col++;
    end
  end
endmodule : ncmo_flash_model
`default_nettype wire

// ### test/ncmo_ctrl_tb.sv
// Self-checking testbench for the cached multi-page flash controller.
`timescale 1ns/1ps
`default_nettype none
module ncmo_ctrl_tb
  import ncmo_pkg::*;
;
  logic ref_clk_i = 0, reset_i = 1, req_valid_i = 0, wp_allow_i = 0;
  logic req_ready_o, busy_o, io_oe_o, ready_busy_n_i;
  logic [7:0] io_o, io_i, got;
  ncmo_req_t req_i = '0;
  ncmo_rsp_t rsp_o;
  ncmo_pins_t pins_o;
  int num_errors = 0, checked = 0, cyc = 0;
  logic [31:0] lf = 32'h0938;
  logic [7:0] em [int];
  logic [7:0] stage [int];
  logic [1:0] es1 = '0, es2 = '0;
  ncmo_ctrl #(.BUSY_TIMEOUT_CYC(200)) dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .req_i(req_i), .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .rsp_o(rsp_o),
    .busy_o(busy_o), .wp_allow_i(wp_allow_i), .pins_o(pins_o), .io_o(io_o),
    .io_oe_o(io_oe_o), .io_i(io_i), .ready_busy_n_i(ready_busy_n_i));
  ncmo_flash_model u_flash (.ref_clk_i(ref_clk_i), .pins_i(pins_o), .bus_i(io_o),
    .bus_o(io_i), .ready_busy_n_o(ready_busy_n_i));
  always #12.5 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) if (rsp_o.valid === 1'b1) got <= rsp_o.data;
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 60000) begin
      num_errors++;
      complete_run();
    end
  end
  function automatic logic [31:0] nx(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : nx
  function automatic logic [7:0] ev(input logic [15:0] p, input logic [11:0] c);
    return em.exists({4'h0, p, c}) ? em[{4'h0, p, c}] : p[7:0] ^ c[7:0] ^ 8'h5A;
  endfunction : ev
  task automatic complete_run();
    $display("checked %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("BAD at %0t: got %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic op(input ncmo_op_t o, input logic [11:0] c, input logic [15:0] p,
                    input logic [15:0] p2, input logic [7:0] d, input logic l);
    int n;
    n = 0;
    @(negedge ref_clk_i);
    req_i <= '{o, c, p, p2, d, l};
    req_valid_i <= 1'b1;
    do begin
      @(negedge ref_clk_i);
      n++;
    end while (busy_o !== 1'b1 && n < 50);
    req_valid_i <= 1'b0;
    chk(8'(n < 50), 8'h01);
    while (busy_o !== 1'b0 && n < 3000) begin
      @(negedge ref_clk_i);
      n++;
    end
    chk(8'(n < 3000), 8'h01);
  endtask : op
  task automatic wr(input int n, input logic [11:0] c);
    for (int i = 0; i < n; i++) begin
      lf = nx(lf);
      stage[c + 12'(i)] = lf[7:0];
      op(NCMO_OP_DATA_IN, '0, '0, '0, lf[7:0], 1'b0);
    end
  endtask : wr
  task automatic pend(input logic [15:0] p, input logic [7:0] cmd);
    op(NCMO_OP_DATA_IN, '0, '0, '0, cmd, 1'b1);
    foreach (stage[k]) em[{4'h0, p, k[11:0]}] = stage[k];
    stage.delete();
    es2[p[15]] = es1[p[15]];
    es1[p[15]] = (p[5:0] == 6'h05);
  endtask : pend
  task automatic rd(input logic [15:0] p, input logic [11:0] c, input int n);
    for (int i = 0; i < n; i++) begin
      op(NCMO_OP_DATA_OUT, '0, '0, '0, '0, 1'b0);
      chk(got, ev(p, c + 12'(i)));
    end
  endtask : rd
  task automatic sts(input ncmo_op_t o);
    op(o, '0, '0, '0, '0, 1'b0);
    chk(got, {wp_allow_i, 2'b11, es2, es1, |es1});
    chk({7'h0, rsp_o.error}, {7'h0, es1 != 2'b00});
  endtask : sts
  initial begin
    repeat (20) @(negedge ref_clk_i);
    reset_i <= 1'b0;
    sts(NCMO_OP_STATUS);
    wp_allow_i <= 1'b1;
    sts(NCMO_OP_STATUS_MP);
    $display("test status done");
    op(NCMO_OP_PROG, 12'h010, 16'h0043, '0, '0, 1'b0);
    wr(4, 12'h010);
    op(NCMO_OP_COL_CHG, 12'h200, 16'h0043, '0, '0, 1'b0);
    wr(3, 12'h200);
    pend(16'h0043, CMD_PROG);
    op(NCMO_OP_READ, 12'h200, 16'h0043, '0, '0, 1'b0);
    rd(16'h0043, 12'h200, 3);
    op(NCMO_OP_READ, 12'h010, 16'h0043, '0, '0, 1'b0);
    rd(16'h0043, 12'h010, 4);
    op(NCMO_OP_CACHE_NEXT, '0, '0, '0, '0, 1'b0);
    chk({7'h0, rsp_o.error}, 8'h00);
    rd(16'h0044, 12'h000, 2);
    op(NCMO_OP_CACHE_LAST, '0, '0, '0, '0, 1'b0);
    rd(16'h0045, 12'h000, 2);
    op(NCMO_OP_READ, 12'h000, 16'h007F, '0, '0, 1'b0);
    op(NCMO_OP_CACHE_NEXT, '0, '0, '0, '0, 1'b0);
    chk({7'h0, rsp_o.error}, 8'h01);
    $display("test program and cached read done");
    op(NCMO_OP_CACHE_PROG, 12'h000, 16'h8005, '0, '0, 1'b0);
    wr(2, 12'h000);
    pend(16'h8005, CMD_CACHE_PROG);
    sts(NCMO_OP_STATUS);
    op(NCMO_OP_PROG, 12'h000, 16'h8006, '0, '0, 1'b0);
    wr(2, 12'h000);
    pend(16'h8006, CMD_PROG);
    sts(NCMO_OP_STATUS_MP);
    $display("test cached program done");
    op(NCMO_OP_MP_READ, 12'h004, 16'h8010, 16'h0010, '0, 1'b0);
    chk({7'h0, rsp_o.error}, 8'h00);
    rd(16'h0010, 12'h004, 2);
    wp_allow_i <= 1'b0;
    op(NCMO_OP_MP_READ, 12'h000, 16'h0010, 16'h8011, '0, 1'b0);
    chk({7'h0, rsp_o.error}, 8'h01);
    op(NCMO_OP_MP_READ, 12'h000, 16'h0010, 16'h0050, '0, 1'b0);
    chk({7'h0, rsp_o.error}, 8'h01);
    $display("test multi-page read done");
    complete_run();
  end
endmodule : ncmo_ctrl_tb
`default_nettype wire
